/* File: tcp_pkg.sv */
// shared constants and helpers of the timing controller host access block
package tcp_pkg;
  localparam int CNT_N = 5;
  // data pointer group and element codes
  localparam logic [2:0] GRP_FIRST = 3'h1;
  localparam logic [2:0] GRP_LAST = 3'h5;
  localparam logic [2:0] GRP_CTRL = 3'h7;
  localparam logic [1:0] EL_MODE = 2'h0;
  localparam logic [1:0] EL_LOAD = 2'h1;
  localparam logic [1:0] EL_HOLD = 2'h2;
  localparam logic [1:0] EL_LAST = 2'h3;
  localparam logic [1:0] EL_ALM1 = 2'h0;
  localparam logic [1:0] EL_ALM2 = 2'h1;
  localparam logic [1:0] EL_MMODE = 2'h2;
  // master mode bit positions and reset value
  localparam int MM_TOD = 0;
  localparam int MM_CMP1 = 2;
  localparam int MM_CMP2 = 3;
  localparam int MM_BUS16 = 13;
  localparam int MM_SEQ_DIS = 14;
  localparam logic [15:0] MM_RST = 16'h0000;
  // command bytes and opcodes (opcode is command bits 7:5)
  localparam logic [7:0] CMD_MRESET = 8'hff;
  localparam logic [7:0] CMD_SEQ_ON = 8'he0;
  localparam logic [7:0] CMD_SEQ_OFF = 8'he8;
  localparam logic [7:0] CMD_BUS8 = 8'he1;
  localparam logic [7:0] CMD_BUS16 = 8'he9;
  localparam logic [2:0] OP_LDPTR = 3'h0;
  localparam logic [2:0] OP_ARM = 3'h1;
  localparam logic [2:0] OP_LOAD = 3'h2;
  localparam logic [2:0] OP_SAVE = 3'h5;
  localparam logic [2:0] OP_DISARM = 3'h6;
  // counter mode fields
  localparam int CM_GATE = 13;
  localparam int CM_SPOL = 12;
  localparam int CM_SRC = 8;
  localparam int CM_ALT = 6;
  localparam int CM_BCD = 4;
  localparam int CM_UP = 3;
  localparam int CM_OUT = 0;
  localparam logic [2:0] OUT_HI = 3'h1;
  localparam logic [2:0] OUT_TGL = 3'h2;
  localparam logic [2:0] OUT_LO = 3'h5;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] BCD_MAX = 16'h9999;
  localparam logic [15:0] BIN_MAX = 16'hffff;
  // timing counts: internal tick every 16 clocks, time-of-day prescale last values
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TOD_LAST50 = 4'h4;
  localparam logic [3:0] TOD_LAST60 = 4'h5;
  localparam logic [3:0] TOD_LAST100 = 4'h9;

  function automatic logic [15:0] tcp_merge(input logic [15:0] old, input logic [15:0] w,
                                            input logic lo, input logic hi);
    return {hi ? w[15:8] : old[15:8], lo ? w[7:0] : old[7:0]};
  endfunction
endpackage

/* File: tcp_counter.sv */
// one counter group: mode, load and hold registers around a counting core
`timescale 1ns/1ps
module tcp_counter
  import tcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // register writes
  input wire logic [1:0] wr_elem_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [15:0] wdata_i,
  // software commands
  input wire logic arm_i,
  input wire logic disarm_i,
  input wire logic load_i,
  input wire logic save_i,
  // sources and gates
  input wire logic [15:0] src_i,
  input wire logic [4:0] gate_i,
  // state
  output logic [15:0] mode_o,
  output logic [15:0] load_o,
  output logic [15:0] hold_o,
  output logic [15:0] count_o,
  output logic tc_o,
  output logic out_o,
  output logic out_en_o
);
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] load;
    logic [15:0] hold;
    logic [15:0] count;
    logic armed;
    logic src_prev;
    logic alt;
    logic tgl;
    logic tc;
    logic out;
    logic out_en;
  } tcp_cnt_s;
  tcp_cnt_s q, d;

  function automatic logic [15:0] tcp_bcd_step(input logic [15:0] v, input logic up);
    logic [15:0] r;
    logic c;
    logic [3:0] dg;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      dg = v[4*i +: 4];
      if (c && up) begin
        c = (dg == 4'h9);
        dg = c ? 4'h0 : dg + 4'h1;
      end else if (c) begin
        c = (dg == 4'h0);
        dg = c ? 4'h9 : dg - 4'h1;
      end
      r[4*i +: 4] = dg;
    end
    return r;
  endfunction

  logic sel_src, step_en, at_tc, up, bcd;
  logic [7:0] gate_ext;
  logic [15:0] nxt, reload;

  always_comb begin
    d = q;
    d.tc = 1'b0;
    case (wr_elem_i)
      EL_MODE: d.mode = tcp_merge(q.mode, wdata_i, wr_lo_i, wr_hi_i);
      EL_LOAD: d.load = tcp_merge(q.load, wdata_i, wr_lo_i, wr_hi_i);
      default: d.hold = tcp_merge(q.hold, wdata_i, wr_lo_i, wr_hi_i);
    endcase
    // any of 16 sources, either polarity; codes 0, 6 and 7 leave the gate open
    sel_src = src_i[q.mode[CM_SRC +: 4]] ^ q.mode[CM_SPOL];
    gate_ext = {2'b11, gate_i, 1'b1};
    d.src_prev = sel_src;
    step_en = q.armed && gate_ext[q.mode[CM_GATE +: 3]] && sel_src && !q.src_prev;
    up = q.mode[CM_UP];
    bcd = q.mode[CM_BCD];
    at_tc = up ? (q.count == (bcd ? BCD_MAX : BIN_MAX)) : (q.count == 16'h0001);
    nxt = bcd ? tcp_bcd_step(q.count, up) : (up ? q.count + 16'h0001 : q.count - 16'h0001);
    reload = (q.mode[CM_ALT] && q.alt) ? q.hold : q.load;
    if (step_en && at_tc) begin
      d.count = reload;
      d.alt = !q.alt;
      d.tc = 1'b1;
      d.tgl = !q.tgl;
    end else if (step_en) begin
      d.count = nxt;
    end
    if (load_i) begin
      d.count = q.load;
    end
    // capture leaves counting untouched
    if (save_i) begin
      d.hold = q.count;
    end
    if (arm_i) begin
      d.armed = 1'b1;
    end else if (disarm_i) begin
      d.armed = 1'b0;
    end
    d.out_en = 1'b1;
    case (d.mode[CM_OUT +: 3])
      OUT_HI: d.out = d.tc;
      OUT_LO: d.out = !d.tc;
      OUT_TGL: d.out = d.tgl;
      default: begin
        d.out = 1'b0;
        d.out_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mode_o = q.mode;
  assign load_o = q.load;
  assign hold_o = q.hold;
  assign count_o = q.count;
  assign tc_o = q.tc;
  assign out_o = q.out;
  assign out_en_o = q.out_en;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_tc_reload: assert property (step_en && at_tc && !load_i |=> tc_o
    && count_o == $past(reload)) else $error("terminal count did not reload");
endmodule // tcp_counter

/* File: tcp_access.sv */
// host access and five counter groups of the timing controller
`timescale 1ns/1ps
module tcp_access
  import tcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // host bus
  input wire logic host_ctrl_sel_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [15:0] host_data_lines_i,
  output logic [15:0] host_data_lines_o,
  output logic host_data_lines_oe_o,
  // counter pins
  input wire logic [4:0] src_i,
  input wire logic [4:0] gate_i,
  output logic [4:0] cnt_out_o,
  output logic [4:0] cnt_out_oe_o,
  // configuration view
  output logic bus_16bit_o,
  output logic sequencing_disable_bit_o,
  output logic [2:0] ptr_group_o,
  output logic [1:0] ptr_element_o,
  output logic byte_ptr_o
);
  typedef struct packed {
    logic [1:0] elem;
    logic [2:0] grp;
    logic bptr;
    logic [15:0] mm;
    logic [15:0] alm1;
    logic [15:0] alm2;
    logic [15:0] pf;
    logic pf_pend;
    logic [15:0] dout;
    logic doe;
    logic [3:0] div;
    logic tick;
    logic [3:0] tod;
    logic tod_tick;
    logic src0_prev;
    logic [4:0] pin;
    logic [4:0] pin_en;
  } tcp_acc_s;
  tcp_acc_s q, d;

  logic data_acc, data_wr, ctrl_wr, bus16, seq_dis, lo, hi;
  logic [7:0] cmd, status_w;
  logic [15:0] rd_mux, wdat;
  logic [2:0] gi, grp_inc, n_grp;
  logic [1:0] n_elem;
  logic n_bptr;
  logic [3:0] tod_last;
  logic [4:0] c_lo, c_hi, c_arm, c_dis, c_load, c_save;
  logic [15:0] c_mode [CNT_N];
  logic [15:0] c_load_r [CNT_N];
  logic [15:0] c_hold [CNT_N];
  logic [15:0] c_count [CNT_N];
  logic [15:0] c_src [CNT_N];
  logic [4:0] c_tc, c_out, c_en;

  assign bus16 = q.mm[MM_BUS16];
  assign seq_dis = q.mm[MM_SEQ_DIS];
  // the select line splits the bus into its two locations
  assign data_acc = (host_rd_i || host_wr_i) && !host_ctrl_sel_i;
  assign data_wr = host_wr_i && !host_ctrl_sel_i;
  assign ctrl_wr = host_wr_i && host_ctrl_sel_i;
  // only the low byte carries the command, so both bus widths decode alike
  assign cmd = host_data_lines_i[7:0];
  assign status_w = {2'b00, q.pin, q.bptr};
  assign gi = q.grp - GRP_FIRST;
  assign grp_inc = (q.grp == GRP_LAST) ? GRP_FIRST : q.grp + 3'h1;
  // bytes travel on the low lines and fill both lanes
  assign wdat = bus16 ? host_data_lines_i : {2{host_data_lines_i[7:0]}};
  assign lo = data_wr && (bus16 || !q.bptr);
  assign hi = data_wr && (bus16 || q.bptr);

  // register addressed by the pointer
  always_comb begin
    rd_mux = WORD_RST;
    if (q.grp == GRP_CTRL) begin
      case (q.elem)
        EL_ALM1: rd_mux = q.alm1;
        EL_ALM2: rd_mux = q.alm2;
        EL_MMODE: rd_mux = q.mm;
        default: rd_mux = {8'h00, status_w};
      endcase
    end else begin
      case (q.elem)
        EL_MODE: rd_mux = c_mode[gi];
        EL_LOAD: rd_mux = c_load_r[gi];
        default: rd_mux = c_hold[gi];
      endcase
    end
  end

  // pointer after a data transfer
  always_comb begin
    n_elem = q.elem;
    n_grp = q.grp;
    n_bptr = q.bptr;
    if (seq_dis) begin
      n_bptr = q.bptr;
    end else if (!bus16 && !q.bptr) begin
      n_bptr = 1'b1;
    end else begin
      n_bptr = 1'b0;
      if (q.grp == GRP_CTRL) begin
        if (q.elem != EL_LAST) begin
          n_elem = (q.elem == EL_HOLD) ? EL_MODE : q.elem + 2'h1;
        end
      end else if (q.elem == EL_LAST) begin
        n_grp = grp_inc;
      end else if (q.elem == EL_HOLD) begin
        n_elem = EL_MODE;
        n_grp = grp_inc;
      end else begin
        n_elem = q.elem + 2'h1;
      end
    end
  end

  always_comb begin
    d = q;
    d.doe = 1'b0;
    d.tick = 1'b0;
    d.tod_tick = 1'b0;
    c_lo = 5'h00;
    c_hi = 5'h00;
    c_arm = 5'h00;
    c_dis = 5'h00;
    c_load = 5'h00;
    c_save = 5'h00;
    // internal rate as a one-cycle enable
    d.div = q.div + 4'h1;
    if (q.div == TICK_LAST) begin
      d.div = 4'h0;
      d.tick = 1'b1;
    end
    // real-time input on source pin 1, scaled to a 10 Hz tick
    case (q.mm[MM_TOD +: 2])
      2'h1: tod_last = TOD_LAST50;
      2'h2: tod_last = TOD_LAST60;
      default: tod_last = TOD_LAST100;
    endcase
    d.src0_prev = src_i[0];
    if (q.mm[MM_TOD +: 2] != 2'h0 && src_i[0] && !q.src0_prev) begin
      d.tod = q.tod + 4'h1;
      if (q.tod == tod_last) begin
        d.tod = 4'h0;
        d.tod_tick = 1'b1;
      end
    end
    // prefetch one cycle after the pointer moves, so a fresh write is seen
    if (q.pf_pend) begin
      d.pf = rd_mux;
      d.pf_pend = 1'b0;
    end
    if (host_rd_i) begin
      d.doe = 1'b1;
      if (host_ctrl_sel_i) begin
        d.dout = {8'h00, status_w};
      end else if (bus16) begin
        d.dout = q.pf;
      end else begin
        d.dout = {8'h00, q.bptr ? q.pf[15:8] : q.pf[7:0]};
      end
    end
    if (data_wr && q.grp == GRP_CTRL) begin
      case (q.elem)
        EL_ALM1: d.alm1 = tcp_merge(q.alm1, wdat, lo, hi);
        EL_ALM2: d.alm2 = tcp_merge(q.alm2, wdat, lo, hi);
        EL_MMODE: d.mm = tcp_merge(q.mm, wdat, lo, hi);
        default: d.mm = q.mm;
      endcase
    end else begin
      c_lo = lo ? 5'h01 << gi : 5'h00;
      c_hi = hi ? 5'h01 << gi : 5'h00;
    end
    if (data_acc) begin
      d.elem = n_elem;
      d.grp = n_grp;
      d.bptr = n_bptr;
      d.pf_pend = 1'b1;
    end
    if (ctrl_wr) begin
      case (cmd)
        CMD_MRESET: d.mm = MM_RST;
        CMD_SEQ_OFF: d.mm[MM_SEQ_DIS] = 1'b1;
        CMD_SEQ_ON: d.mm[MM_SEQ_DIS] = 1'b0;
        CMD_BUS16: d.mm[MM_BUS16] = 1'b1;
        CMD_BUS8: d.mm[MM_BUS16] = 1'b0;
        default: begin
          case (cmd[7:5])
            OP_LDPTR: begin
              if (cmd[2:0] == GRP_CTRL || (cmd[2:0] >= GRP_FIRST && cmd[2:0] <= GRP_LAST)) begin
                d.grp = cmd[2:0];
                d.elem = cmd[4:3];
                d.bptr = 1'b0;
                d.pf_pend = 1'b1;
              end
            end
            OP_ARM: c_arm = cmd[4:0];
            OP_DISARM: c_dis = cmd[4:0];
            OP_LOAD: c_load = cmd[4:0];
            OP_SAVE: c_save = cmd[4:0];
            default: c_save = 5'h00;
          endcase
        end
      endcase
    end
    // comparators replace the counter output on the first two pins
    for (int i = 0; i < CNT_N; i++) begin
      d.pin[i] = c_out[i];
      d.pin_en[i] = c_en[i];
    end
    if (q.mm[MM_CMP1]) begin
      d.pin[0] = (c_count[0] == q.alm1) ^ c_mode[0][CM_OUT + 2];
      d.pin_en[0] = 1'b1;
    end
    if (q.mm[MM_CMP2]) begin
      d.pin[1] = (c_count[1] == q.alm2) ^ c_mode[1][CM_OUT + 2];
      d.pin_en[1] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.grp <= GRP_FIRST;
    end else begin
      q <= d;
    end
  end

  // source map: pins, gates, previous counter, internal tick, time-of-day tick
  for (genvar i = 0; i < CNT_N; i++) begin : g_cnt
    assign c_src[i] = {q.tod_tick, {4{q.tick}}, c_tc[(i + 4) % CNT_N], gate_i, src_i};
    tcp_counter u_cnt (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .wr_elem_i(q.elem),
      .wr_lo_i(c_lo[i]),
      .wr_hi_i(c_hi[i]),
      .wdata_i(wdat),
      .arm_i(c_arm[i]),
      .disarm_i(c_dis[i]),
      .load_i(c_load[i]),
      .save_i(c_save[i]),
      .src_i(c_src[i]),
      .gate_i(gate_i),
      .mode_o(c_mode[i]),
      .load_o(c_load_r[i]),
      .hold_o(c_hold[i]),
      .count_o(c_count[i]),
      .tc_o(c_tc[i]),
      .out_o(c_out[i]),
      .out_en_o(c_en[i])
    );
  end

  assign host_data_lines_o = q.dout;
  assign host_data_lines_oe_o = q.doe;
  assign cnt_out_o = q.pin;
  assign cnt_out_oe_o = q.pin_en;
  assign bus_16bit_o = q.mm[MM_BUS16];
  assign sequencing_disable_bit_o = q.mm[MM_SEQ_DIS];
  assign ptr_group_o = q.grp;
  assign ptr_element_o = q.elem;
  assign byte_ptr_o = q.bptr;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_status_ctrl_read: assert property (host_rd_i && host_ctrl_sel_i |=>
    host_data_lines_oe_o && host_data_lines_o == {8'h00, $past(status_w)})
    else $error("control read did not return status");
  chk_seq_hold_ptr: assert property (seq_dis && data_acc |=>
    $stable({q.elem, q.grp, q.bptr})) else $error("pointer moved while sequencing off");
  chk_byte_toggle: assert property (!bus16 && !seq_dis && data_acc |=>
    q.bptr != $past(q.bptr)) else $error("byte pointer did not toggle");
  chk_elem_cycle: assert property (!seq_dis && data_acc && (bus16 || q.bptr)
    && q.grp != GRP_CTRL && q.elem != EL_LAST |=>
    q.elem == (($past(q.elem) == EL_HOLD) ? EL_MODE : $past(q.elem) + 2'h1))
    else $error("element cycle step wrong");
  chk_group_legal: assert property (q.grp != 3'h0 && q.grp != 3'h6)
    else $error("group left the legal codes");
  chk_status_park: assert property (data_acc && q.grp == GRP_CTRL && q.elem == EL_LAST
    |=> q.grp == GRP_CTRL && q.elem == EL_LAST) else $error("status pointer moved");
  chk_hold_cycle: assert property (!seq_dis && data_acc && (bus16 || q.bptr)
    && q.grp != GRP_CTRL && q.elem == EL_LAST |=> q.elem == EL_LAST
    && q.grp == $past(grp_inc)) else $error("hold cycle step wrong");
  chk_prefetch_fill: assert property (data_acc |=> q.pf_pend ##1
    q.pf == $past(rd_mux)) else $error("prefetch missed");
  chk_mreset_clear: assert property (ctrl_wr && cmd == CMD_MRESET |=>
    q.mm == MM_RST) else $error("master reset left master mode set");

  cov_load_ptr: cover property (ctrl_wr && cmd[7:5] == OP_LDPTR);
  cov_group_wrap: cover property (data_acc && q.grp == GRP_LAST ##1 q.grp == GRP_FIRST);
  cov_byte_pair: cover property (!bus16 && data_acc && !q.bptr ##[1:8] data_acc && q.bptr);
endmodule // tcp_access

/* File: tcp_host_model.sv */
// host processor model driving the timing controller bus
`timescale 1ns/1ps
module tcp_host_model (
  // clock
  input wire logic clk_sys_i,
  // host bus
  output logic host_ctrl_sel_o,
  output logic host_rd_o,
  output logic host_wr_o,
  output logic [15:0] host_data_lines_o,
  input wire logic [15:0] host_data_lines_i,
  input wire logic host_data_lines_oe_i,
  input wire logic bus_16bit_i
);
  initial begin
    host_ctrl_sel_o = 1'b0;
    host_rd_o = 1'b0;
    host_wr_o = 1'b0;
    host_data_lines_o = 16'h5aa5;
  end

  // idle gap first: a data read needs one quiet cycle after the pointer moves
  task automatic wr(input logic sel, input logic [15:0] val);
    repeat (3) @(posedge clk_sys_i);
    #1;
    host_ctrl_sel_o = sel;
    // narrow bus: upper lines carry no data, so they get junk
    host_data_lines_o = bus_16bit_i ? val : {~val[15:8], val[7:0]};
    host_wr_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    host_wr_o = 1'b0;
    // released lines must not keep the last value
    host_data_lines_o = ~host_data_lines_o;
  endtask

  task automatic rd(input logic sel, output logic [15:0] val, output logic ok);
    int n;
    repeat (3) @(posedge clk_sys_i);
    #1;
    host_ctrl_sel_o = sel;
    host_rd_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    host_rd_o = 1'b0;
    n = 0;
    while (host_data_lines_oe_i !== 1'b1 && n < 4) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    ok = (host_data_lines_oe_i === 1'b1);
    val = host_data_lines_i;
  endtask
endmodule // tcp_host_model

/* File: tb.sv */
// self-checking testbench of the timing controller host access block
`timescale 1ns/1ps
module tb;
  import tcp_pkg::*;
  logic clk_sys_i;
  logic rst_b_i;
  logic sel;
  logic rd;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic oe;
  logic [4:0] src;
  logic [4:0] gate;
  logic [4:0] cnt_out;
  logic [4:0] cnt_oe;
  logic bus16;
  logic seq_dis;
  logic [2:0] grp;
  logic [1:0] elem;
  logic byte_ptr;
  int fails;
  int compares;

  tcp_access tcp_access_inst (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .host_ctrl_sel_i(sel), .host_rd_i(rd),
    .host_wr_i(wr), .host_data_lines_i(wdata), .host_data_lines_o(rdata),
    .host_data_lines_oe_o(oe), .src_i(src), .gate_i(gate), .cnt_out_o(cnt_out),
    .cnt_out_oe_o(cnt_oe), .bus_16bit_o(bus16), .sequencing_disable_bit_o(seq_dis),
    .ptr_group_o(grp), .ptr_element_o(elem), .byte_ptr_o(byte_ptr)
  );

  tcp_host_model tcp_host_model_inst (
    .clk_sys_i(clk_sys_i), .host_ctrl_sel_o(sel), .host_rd_o(rd), .host_wr_o(wr),
    .host_data_lines_o(wdata), .host_data_lines_i(rdata), .host_data_lines_oe_i(oe),
    .bus_16bit_i(bus16)
  );

  initial clk_sys_i = 1'b0;
  always #20 clk_sys_i = ~clk_sys_i;

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cw(input logic [15:0] v);
    tcp_host_model_inst.wr(1'b1, v);
  endtask

  task automatic dw(input logic [15:0] v);
    tcp_host_model_inst.wr(1'b0, v);
  endtask

  task automatic rd_chk(input logic s, input logic [15:0] exp);
    logic [15:0] v;
    logic ok;
    tcp_host_model_inst.rd(s, v, ok);
    if (!ok) begin
      fails++;
      $display("CHECK FAILED at %0t: read never answered", $time);
      end_sim();
    end else begin
      chk(v, exp);
    end
  endtask

  // pointer state as {byte, element, group}, sampled once it has settled
  task automatic pchk(input logic [5:0] exp);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({10'h000, byte_ptr, elem, grp}, {10'h000, exp});
  endtask

  task automatic pulse();
    @(posedge clk_sys_i);
    #1;
    src[0] = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    src[0] = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask

  initial begin
    fails = 0;
    compares = 0;
    src = 5'h00;
    gate = 5'h00;
    rst_b_i = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    pchk(6'b0_00_001);
    chk({14'h0000, bus16, seq_dis}, 16'h0000);
    $display("test reset done");

    cw(16'h0009);
    pchk(6'b0_01_001);
    dw(16'h0034);
    pchk(6'b1_01_001);
    rd_chk(1'b1, 16'h0001);
    dw(16'h0012);
    pchk(6'b0_10_001);
    cw(16'h0009);
    rd_chk(1'b0, 16'h0034);
    rd_chk(1'b0, 16'h0012);
    $display("test byte pairs done");

    cw(16'h0015);
    rd_chk(1'b0, 16'h0000);
    rd_chk(1'b0, 16'h0000);
    pchk(6'b0_00_001);
    cw(16'h001d);
    rd_chk(1'b0, 16'h0000);
    rd_chk(1'b0, 16'h0000);
    pchk(6'b0_11_001);
    cw(16'h0017);
    rd_chk(1'b0, 16'h0000);
    rd_chk(1'b0, 16'h0000);
    pchk(6'b0_00_111);
    cw(16'h001f);
    rd_chk(1'b0, 16'h0000);
    dw(16'h00ff);
    rd_chk(1'b0, 16'h0000);
    chk({11'h000, elem, grp}, 16'h001f);
    $display("test sequencing done");

    cw({8'h00, CMD_SEQ_OFF});
    pchk(6'b1_11_111);
    chk({15'h0000, seq_dis}, 16'h0001);
    cw(16'h0009);
    dw(16'h0056);
    dw(16'h0078);
    pchk(6'b0_01_001);
    cw({8'h00, CMD_MRESET});
    pchk(6'b0_01_001);
    chk({15'h0000, seq_dis}, 16'h0000);
    cw(16'h0009);
    rd_chk(1'b0, 16'h0078);
    rd_chk(1'b0, 16'h0012);
    $display("test sequencing off done");

    cw({8'h00, CMD_BUS16});
    cw(16'hff09);
    dw(16'h0002);
    pchk(6'b0_10_001);
    chk({15'h0000, bus16}, 16'h0001);
    cw(16'hff09);
    rd_chk(1'b0, 16'h0002);
    cw(16'hff01);
    dw(16'h0002);
    pchk(6'b0_01_001);
    chk({11'h000, cnt_oe}, 16'h0001);
    cw(16'h0041);
    cw(16'h0021);
    pulse();
    chk({15'h0000, cnt_out[0]}, 16'h0000);
    pulse();
    chk({15'h0000, cnt_out[0]}, 16'h0001);
    cw(16'h00a1);
    cw(16'hff11);
    rd_chk(1'b0, 16'h0002);
    pulse();
    cw(16'h00a1);
    cw(16'hff11);
    rd_chk(1'b0, 16'h0001);
    cw({8'h00, CMD_BUS8});
    pchk(6'b0_00_010);
    chk({15'h0000, bus16}, 16'h0000);
    // alarm 5 against count 1: comparator pulls the toggled pin low
    cw(16'h0007);
    dw(16'h0005);
    dw(16'h0000);
    dw(16'h0000);
    dw(16'h0000);
    dw(16'h0004);
    dw(16'h0000);
    pchk(6'b0_00_111);
    chk({15'h0000, cnt_out[0]}, 16'h0000);
    $display("test counter done");
    end_sim();
  end
endmodule // tb
